// ---- rtfc_params.svh ----
// Constants for the RTC flags and control register block.
// Assumes a 100 MHz clock and an APB register port.
`ifndef RTFC_PARAMS_SVH
`define RTFC_PARAMS_SVH
// Register byte offsets
`define RTFC_OFF_FLAGS 12'h000
`define RTFC_OFF_IRQ_STAT 12'h004
`define RTFC_OFF_IRQ_MASK 12'h008
`define RTFC_OFF_TIME 12'h00c
`define RTFC_OFF_HOLD 12'h010
// Flag register bit positions
`define RTFC_BIT_W 1
`define RTFC_BIT_CAL 2
`define RTFC_BIT_OSC_FAIL 4
`define RTFC_BIT_PWR_FAIL 5
`define RTFC_BIT_R 0
// Flag register reset value
`define RTFC_FLAGS_RST 8'h00
// Interrupt status bit positions
`define RTFC_IRQ_PWR_FAIL 0
`define RTFC_IRQ_OSC_FAIL 1
// Timing: start-up check 5 ms, update delay in us, 512 Hz wave
`define RTFC_CLK_HZ 100000000
`define RTFC_START_MS 5
`define RTFC_UPD_US 1
`define RTFC_CAL_HZ 512
`define RTFC_START_CYC ((`RTFC_CLK_HZ / 1000) * `RTFC_START_MS)
`define RTFC_UPD_CYC ((`RTFC_CLK_HZ / 1000000) * `RTFC_UPD_US)
`define RTFC_HALF_CYC (`RTFC_CLK_HZ / (2 * `RTFC_CAL_HZ))
`endif

// ---- rtfc_pkg.sv ----
// Types shared by the RTC flags block.
// Assumes nothing beyond the params header.
package rtfc_pkg;
    typedef enum logic [1:0] {ST_CHECK, ST_RUN} rtfc_state_t;
endpackage

// ---- rtfc_top.sv ----
// RTC flags and control register with APB slave and interrupt.
// Assumes osc_running and below_switch come from other domains.
`timescale 1ns/100ps
`include "rtfc_params.svh"

// How it works
// RL1: Reading the flags register clears power-fail; reset clears it too.
// RL2: Oscillator enabled but not running after 5 ms sets oscillator-fail.
// RL3: Oscillator-fail is never cleared by hardware, only by software write; the code also clears it on reset_n low.
// RL4: Software checks oscillator-fail and writes 0 to clear it.
// RL5: A cleared oscillator-fail bit shows only after the update delay.
// RL6: Calibration bit set drives 512 Hz square wave on interrupt pin.
// RL7: Calibration bit resets to 0 at power-up.
// RL8: Read-enable set stops copying live time into holding register.
// RL9: Write-enable set freezes holding; clearing it loads changes into counter.
// RL10: Supply below power-switch threshold sets power-fail.
module rtfc_top
    import rtfc_pkg::*;
    #(
    parameter int START_CYC = `RTFC_START_CYC, // Start-up check length
    parameter int HALF_CYC = `RTFC_HALF_CYC // Half period of cal wave
    )
    (
    input wire logic clk, // 100 MHz clock
    input wire logic reset_n, // Async reset, active low (power-up)
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic osc_enable, // Oscillator enabled
    input wire logic osc_running, // Oscillator running, async
    input wire logic below_switch, // Supply below power_switch_threshold, async
    input wire logic time_tick, // Seconds advance, same domain
    output logic int_out // Interrupt / calibration pin
    );

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [1:0] osc_sync_reg;
    logic [1:0] low_sync_reg;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            osc_sync_reg <= 2'h0;
            low_sync_reg <= 2'h0;
        end
        else
        begin
            osc_sync_reg <= {osc_sync_reg[0], osc_running};
            low_sync_reg <= {low_sync_reg[0], below_switch};
        end
    end
    wire osc_ok = osc_sync_reg[1];
    wire supply_low = low_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit_flags = paddr == `RTFC_OFF_FLAGS;
    wire hit_stat = paddr == `RTFC_OFF_IRQ_STAT;
    wire hit_mask = paddr == `RTFC_OFF_IRQ_MASK;
    wire hit_time = paddr == `RTFC_OFF_TIME;
    wire hit_hold = paddr == `RTFC_OFF_HOLD;
    wire hit_any = hit_flags | hit_stat | hit_mask | hit_time | hit_hold;
    wire wr_flags = wr && hit_flags;
    wire rd_flags = rd && hit_flags;

    ////////////////////////////////////////////////////////////////////////
    // Flags register state
    logic power_fail_flag_reg, oscillator_fail_flag_reg, cal_reg, wen_reg, ren_reg;
    logic osc_fail_clr_pend_reg;
    logic [31:0] upd_cnt_reg;
    rtfc_state_t state_reg;
    logic [31:0] start_cnt_reg;
    logic power_fail_set, osc_fail_set;
    assign power_fail_set = supply_low; // RL10
    assign osc_fail_set = (state_reg == ST_CHECK) && osc_enable && !osc_ok
                      && (start_cnt_reg == 32'(START_CYC - 1)); // RL2

    // Power-up oscillator check
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= ST_CHECK;
            start_cnt_reg <= 32'h0;
        end
        else
        begin
            case (state_reg)
                ST_CHECK:
                begin
                    start_cnt_reg <= start_cnt_reg + 32'h1;
                    if (start_cnt_reg == 32'(START_CYC - 1))
                        state_reg <= ST_RUN; // RL2
                end
                ST_RUN: state_reg <= ST_RUN;
                default: state_reg <= ST_CHECK;
            endcase
        end
    end

    // Power-fail flag: set wins over read clear
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            power_fail_flag_reg <= 1'h0; // RL1
        else if (power_fail_set)
            power_fail_flag_reg <= 1'h1; // RL10
        else if (rd_flags)
            power_fail_flag_reg <= 1'h0; // RL1
    end

    // Oscillator-fail flag; its reset stands in for a retained value
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            oscillator_fail_flag_reg <= 1'h0;
            osc_fail_clr_pend_reg <= 1'h0;
            upd_cnt_reg <= 32'h0;
        end
        else if (osc_fail_set)
        begin
            oscillator_fail_flag_reg <= 1'h1; // RL2
            osc_fail_clr_pend_reg <= 1'h0;
        end
        else if (wr_flags && !pwdata[`RTFC_BIT_OSC_FAIL] && oscillator_fail_flag_reg)
        begin
            osc_fail_clr_pend_reg <= 1'h1; // RL4
            upd_cnt_reg <= 32'h0;
        end
        else if (osc_fail_clr_pend_reg)
        begin
            upd_cnt_reg <= upd_cnt_reg + 32'h1;
            if (upd_cnt_reg == 32'(`RTFC_UPD_CYC - 1))
            begin
                oscillator_fail_flag_reg <= 1'h0; // RL5
                osc_fail_clr_pend_reg <= 1'h0; // RL3
            end
        end
    end

    // Control bits
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cal_reg <= 1'h0; // RL7
            wen_reg <= 1'h0;
            ren_reg <= 1'h0;
        end
        else if (wr_flags)
        begin
            cal_reg <= pwdata[`RTFC_BIT_CAL]; // RL6
            wen_reg <= pwdata[`RTFC_BIT_W];
            ren_reg <= pwdata[`RTFC_BIT_R];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time counter and holding register
    logic [31:0] time_reg, hold_reg;
    logic hold_dirty_reg;
    wire wr_hold = wr && hit_hold && wen_reg;
    wire wen_fall = wr_flags && wen_reg && !pwdata[`RTFC_BIT_W];
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            time_reg <= 32'h0;
            hold_reg <= 32'h0;
            hold_dirty_reg <= 1'h0;
        end
        else
        begin
            if (wen_fall && hold_dirty_reg)
                time_reg <= hold_reg; // RL9
            else if (time_tick)
                time_reg <= time_reg + 32'h1;
            if (wr_hold)
                hold_reg <= pwdata;
            else if (!ren_reg && !wen_reg)
                hold_reg <= time_reg; // RL8
            if (wr_hold)
                hold_dirty_reg <= 1'h1;
            else if (wen_fall)
                hold_dirty_reg <= 1'h0; // RL9
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask
    logic [1:0] stat_reg, mask_reg;
    wire [1:0] ev = {osc_fail_set, power_fail_set && !power_fail_flag_reg};
    wire [1:0] stat_clr = (wr && hit_stat) ? pwdata[1:0] : 2'h0;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stat_reg <= 2'h0;
            mask_reg <= 2'h0;
        end
        else
        begin
            stat_reg <= (stat_reg & ~stat_clr) | ev;
            if (wr && hit_mask)
                mask_reg <= pwdata[1:0];
        end
    end

    // 512 Hz calibration wave
    logic [31:0] half_cnt_reg;
    logic wave_reg;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            half_cnt_reg <= 32'h0;
            wave_reg <= 1'h0;
        end
        else if (!cal_reg)
        begin
            half_cnt_reg <= 32'h0;
            wave_reg <= 1'h0;
        end
        else if (half_cnt_reg == 32'(HALF_CYC - 1))
        begin
            half_cnt_reg <= 32'h0;
            wave_reg <= !wave_reg; // RL6
        end
        else
            half_cnt_reg <= half_cnt_reg + 32'h1;
    end

    wire irq_next = cal_reg ? wave_reg : |(stat_reg & mask_reg); // RL6

    ////////////////////////////////////////////////////////////////////////
    // Read mux and outputs
    wire [7:0] flags_val = {2'h0, power_fail_flag_reg, oscillator_fail_flag_reg, 1'h0, cal_reg, wen_reg, ren_reg};
    wire [31:0] rd_mux = hit_flags ? {24'h0, flags_val} :
                         hit_stat ? {30'h0, stat_reg} :
                         hit_mask ? {30'h0, mask_reg} :
                         hit_time ? time_reg :
                         hit_hold ? hold_reg : 32'h0;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata <= 32'h0;
            pready <= 1'h0;
            pslverr <= 1'h0;
            int_out <= 1'h0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
            int_out <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_pwr_fail_clear: assert property (@(posedge clk) disable iff (!reset_n)
        rd_flags && pready && !power_fail_set |=> !power_fail_flag_reg)
        else $error("power fail flag not cleared by read"); // RL1
    a_osc_fail_sticky: assert property (@(posedge clk) disable iff (!reset_n)
        oscillator_fail_flag_reg && !osc_fail_clr_pend_reg |=> oscillator_fail_flag_reg)
        else $error("oscillator fail flag cleared by itself"); // RL3
    a_cal_wave: assert property (@(posedge clk) disable iff (!reset_n)
        cal_reg && $past(cal_reg) |=> int_out == $past(wave_reg)) else $error("cal wave missing"); // RL6
    a_pwr_fail_set: assert property (@(posedge clk) disable iff (!reset_n)
        supply_low |=> power_fail_flag_reg) else $error("power fail flag not set"); // RL10
    a_osc_clear_early: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(osc_fail_clr_pend_reg) |-> oscillator_fail_flag_reg)
        else $error("oscillator fail flag cleared early"); // RL5
    // The flag may only drop once the update delay counter has run out
    a_osc_clear_delay: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(oscillator_fail_flag_reg) |-> $past(upd_cnt_reg) == 32'(`RTFC_UPD_CYC - 1))
        else $error("oscillator fail flag cleared before update delay"); // RL5
endmodule // rtfc_top

// ---- tb_rtfc_top.sv ----
// Self-checking bench for the RTC flags block: APB tasks and directed tests.
// Assumes the params header and package are compiled first; one 100 MHz clock.
`timescale 1ns/100ps
`include "rtfc_params.svh"
module tb_rtfc_top;
    import rtfc_pkg::*;
    localparam int START_SIM = 50;
    localparam int HALF_SIM = 4;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic osc_enable = 1'b1;
    logic osc_running = 1'b1;
    logic below_switch = 1'b0;
    logic time_tick = 1'b0;
    logic int_out;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    int toggles;
    logic last;
    //////////////////////////////////////////////////////////////////////////
    rtfc_top #(.START_CYC(START_SIM), .HALF_CYC(HALF_SIM)) uut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_enable(osc_enable), .osc_running(osc_running), .below_switch(below_switch),
        .time_tick(time_tick), .int_out(int_out));
    // Clock generation
    initial
    begin
        forever #5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail = n_fail + 1;
            end_of_test();
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // One comparison
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One APB transfer, waits for pready at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h00000000, r, e);
        chk(name, exp, r);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk);
            time_tick <= 1'b1;
            @(posedge clk);
            time_tick <= 1'b0;
        end
        wait_cyc(3);
    endtask
    //////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [31:0] r;
        logic e;
        wait_cyc(2);
        reset_n <= 1'b1;
        // Reset values and unmapped access
        rd(`RTFC_OFF_FLAGS, 32'h00000000, "flags_reset");
        apb(1'b0, 12'h020, 32'h00000000, r, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, r);
        $display("Test reset done");
        // Holding copy follows live time, stops on R, loads on W release
        tick(3);
        rd(`RTFC_OFF_TIME, 32'h3, "time_live");
        rd(`RTFC_OFF_HOLD, 32'h3, "hold_live");
        wr(`RTFC_OFF_FLAGS, 32'h01);
        tick(2);
        rd(`RTFC_OFF_TIME, 32'h5, "time_r_set");
        rd(`RTFC_OFF_HOLD, 32'h3, "hold_frozen");
        wr(`RTFC_OFF_FLAGS, 32'h00);
        wait_cyc(3);
        rd(`RTFC_OFF_HOLD, 32'h5, "hold_resumed");
        wr(`RTFC_OFF_FLAGS, 32'h02);
        wr(`RTFC_OFF_HOLD, 32'h55);
        tick(1);
        rd(`RTFC_OFF_HOLD, 32'h55, "hold_w_frozen");
        wr(`RTFC_OFF_FLAGS, 32'h00);
        wait_cyc(3);
        rd(`RTFC_OFF_TIME, 32'h55, "time_loaded");
        $display("Test holding done");
        // Power fail flag, read clear and interrupt
        wr(`RTFC_OFF_IRQ_MASK, 32'h1);
        below_switch <= 1'b1;
        wait_cyc(6);
        chk("int_pf", 32'h1, {31'h0, int_out});
        below_switch <= 1'b0;
        wait_cyc(6);
        rd(`RTFC_OFF_FLAGS, 32'h20, "flags_pf");
        rd(`RTFC_OFF_FLAGS, 32'h00, "flags_pf_cleared");
        wr(`RTFC_OFF_IRQ_STAT, 32'h1);
        wait_cyc(3);
        rd(`RTFC_OFF_IRQ_STAT, 32'h0, "irq_stat_w1c");
        chk("int_cleared", 32'h0, {31'h0, int_out});
        $display("Test power fail done");
        // Calibration wave: 80 cycles hold 20 half periods of 4
        wr(`RTFC_OFF_FLAGS, 32'h04);
        rd(`RTFC_OFF_FLAGS, 32'h04, "flags_cal");
        toggles = 0;
        last = int_out;
        repeat (80)
        begin
            @(posedge clk);
            if (int_out !== last)
                toggles = toggles + 1;
            last = int_out;
        end
        chk("cal_toggles_lo", 32'h1, {31'h0, toggles >= 19});
        chk("cal_toggles_hi", 32'h1, {31'h0, toggles <= 21});
        wr(`RTFC_OFF_FLAGS, 32'h00);
        wait_cyc(3);
        chk("int_after_cal", 32'h0, {31'h0, int_out});
        $display("Test calibration done");
        // Oscillator fail on power-up, kept until software clears it; cal set before reset and cleared by it
        wr(`RTFC_OFF_FLAGS, 32'h04);
        osc_running <= 1'b0;
        reset_n <= 1'b0;
        wait_cyc(2);
        reset_n <= 1'b1;
        wait_cyc(START_SIM + 10);
        rd(`RTFC_OFF_FLAGS, 32'h10, "flags_oscillator_fail_flag");
        rd(`RTFC_OFF_IRQ_STAT, 32'h2, "irq_stat_oscillator_fail_flag");
        wait_cyc(200);
        rd(`RTFC_OFF_FLAGS, 32'h10, "oscillator_fail_flag_kept");
        wr(`RTFC_OFF_FLAGS, 32'h00);
        rd(`RTFC_OFF_FLAGS, 32'h10, "oscillator_fail_flag_delay");
        wait_cyc(`RTFC_UPD_CYC + 10);
        rd(`RTFC_OFF_FLAGS, 32'h00, "oscillator_fail_flag_cleared");
        // Oscillator disabled: no fail flag after the start-up check
        osc_enable <= 1'b0;
        reset_n <= 1'b0;
        wait_cyc(2);
        reset_n <= 1'b1;
        wait_cyc(START_SIM + 10);
        rd(`RTFC_OFF_FLAGS, 32'h00, "osc_disabled");
        $display("Test oscillator fail done");
        end_of_test();
    end
endmodule // tb_rtfc_top
